//--- hdl/pot_map.vh
// constants for the wiper control block: codes, field positions, timing
`ifndef POT_MAP_VH
`define POT_MAP_VH
`define CMD_NOP 4'h0
`define CMD_RESTORE 4'h1
`define CMD_STORE_WIPER 4'h2
`define CMD_STORE_ANY 4'h3
`define CMD_HALVE_A 4'h4
`define CMD_HALVE_B 4'h5
`define CMD_DEC_A 4'h6
`define CMD_DEC_B 4'h7
`define CMD_RESET_NV 4'h8
`define CMD_READ_NV 4'h9
`define CMD_READ_WIPER 4'hA
`define CMD_WRITE_WIPER 4'hB
`define CMD_DOUBLE_A 4'hC
`define CMD_DOUBLE_B 4'hD
`define CMD_INC_A 4'hE
`define CMD_INC_B 4'hF
`define CMD_MSB 23
`define CMD_LSB 20
`define ADDR_MSB 19
`define ADDR_LSB 16
`define WIPER_ADDR 4'h0
`define WIPER_MID 10'h200
`define WIPER_FULL 10'h3FF
`define FRAME_BITS 24
`define STORE_TIME_MS 25
`define CLK_MHZ 250
`define STORE_CYCLES (`STORE_TIME_MS * 1000 * `CLK_MHZ)
`define RESTORE_CYCLES 32
`define READY_PULSE_CYCLES 8
`endif

//--- hdl/nv_mem.v
// small nonvolatile word store model with registered read data
`timescale 1ns/1ps
`include "pot_map.vh"
module nv_mem #(
	parameter AW = 4,
	parameter DW = 16
) (
	input wire clk,
	input wire rst_b,
	input wire ce,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata_ff
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	reg init_done_ff;
	integer i;
	// factory contents: wiper location at midscale, user words zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= {DW{1'b0}};
			init_done_ff <= 1'b0;
		end else if (ce) begin
			if (!init_done_ff) begin
				for (i = 0; i < (1<<AW); i = i + 1) begin
					mem[i] <= {DW{1'b0}};
				end
				mem[0] <= {{(DW-10){1'b0}}, `WIPER_MID};
				init_done_ff <= 1'b1;
			end else if (we) begin
				mem[addr] <= wdata;
			end
			rdata_ff <= mem[addr];
		end
	end
endmodule

//--- hdl/pin_sync.v
// two-flop synchronisers for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter N = 5,
	parameter [N-1:0] INIT = {N{1'b1}}
) (
	input wire clk,
	input wire rst_b,
	input wire ce,
	input wire [N-1:0] d,
	output reg [N-1:0] q_ff
);
	reg [N-1:0] meta_ff;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= INIT;
			q_ff <= INIT;
		end else if (ce) begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end
endmodule

//--- hdl/wiper_ctrl.v
// wiper command interpreter: serial port, wiper register, nv store control
// Behaviour
// - wiper output follows wiper register while preset is high
// - store lasts 25 ms, shifter locked
// - ready pulses low when store ends
// - command 0xB address 0 loads wiper
// - command 0x2 stores wiper to nv
// - command 3 stores wiper or data
// - commands 1 and 8 restore wiper
// - commands 9, 10 read back on output
// - commands 4,5 halve; 12,13 double
// - commands 6,7 decrement; 14,15 increment
// - power-on loads wiper from nv
// - nv wiper defaults to midscale
// - preset low forces midscale, rise restores
// - bare chip-select strobe repeats adjustment
// - write protect blocks all but restores and reads
// - serial output released while select high
// - other commands echo previous word
// - 24-bit msb first, decode on select rise
// - bit count not multiple four discards
// - command, address, then data fields
// - ready marks end of 1,2,3,8,9,10,preset
`timescale 1ns/1ps
`include "pot_map.vh"
module wiper_ctrl #(
	parameter STORE_CYCLES = `STORE_CYCLES
) (
	input wire clk,
	input wire rst_b,
	input wire ce,
	input wire sclk,
	input wire sdi,
	input wire cs_n,
	input wire wp_n,
	input wire preset_strobe_n,
	output reg sdo_o_ff,
	output wire sdo_oe_n,
	output reg rdy_o_ff,
	output wire rdy_oe_n,
	output wire [9:0] wiper_pos,
	output reg busy_ff
);
	localparam ST_POR = 3'd0;
	localparam ST_POR_RD = 3'd1;
	localparam ST_IDLE = 3'd2;
	localparam ST_STORE = 3'd3;
	localparam ST_RD_WAIT = 3'd4;
	localparam ST_RD_DONE = 3'd5;
	localparam ST_READY = 3'd6;

	wire sclk_s;
	wire sdi_s;
	wire cs_s;
	wire wp_s;
	wire pr_s;
	wire [4:0] pin_s;
	// reset values match the idle pin levels so no false edge follows reset
	pin_sync #(.N(5), .INIT(5'h0F)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.d({sclk, sdi, cs_n, wp_n, preset_strobe_n}),
		.q_ff(pin_s)
	);
	assign sclk_s = pin_s[4];
	assign sdi_s = pin_s[3];
	assign cs_s = pin_s[2];
	assign wp_s = pin_s[1];
	assign pr_s = pin_s[0];

	reg sclk_d_ff;
	reg cs_d_ff;
	reg pr_d_ff;
	wire sclk_rise = sclk_s & ~sclk_d_ff;
	wire sclk_fall = ~sclk_s & sclk_d_ff;
	wire cs_rise = cs_s & ~cs_d_ff;
	wire pr_rise = pr_s & ~pr_d_ff;

	// edge finders sit behind the synchronisers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
			pr_d_ff <= 1'b1;
		end else if (ce) begin
			sclk_d_ff <= sclk_s;
			cs_d_ff <= cs_s;
			pr_d_ff <= pr_s;
		end
	end

	reg [23:0] shift_ff;
	reg [23:0] out_ff;
	reg [5:0] bit_cnt_ff;
	reg [23:0] last_word_ff;
	reg [3:0] rpt_cmd_ff;
	reg rpt_ok_ff;
	reg [9:0] wiper_ff;
	reg [2:0] state_ff;
	reg [31:0] timer_ff;
	reg [3:0] nv_addr_ff;
	reg [15:0] nv_wdata_ff;
	reg nv_we_ff;
	reg nv_rd_is_read_ff;
	// a preset rise seen while busy is kept until the block is idle again
	reg pr_pend_ff;
	wire [15:0] nv_rdata;

	nv_mem #(.AW(4), .DW(16)) u_nv (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.we(nv_we_ff),
		.addr(nv_addr_ff),
		.wdata(nv_wdata_ff),
		.rdata_ff(nv_rdata)
	);

	// while preset is low the wiper shows midscale without touching the reg
	assign wiper_pos = pr_s ? wiper_ff : `WIPER_MID;
	assign sdo_oe_n = cs_s | sdo_o_ff;
	assign rdy_oe_n = rdy_o_ff;

	wire [3:0] f_cmd = shift_ff[`CMD_MSB:`CMD_LSB];
	wire [3:0] f_addr = shift_ff[`ADDR_MSB:`ADDR_LSB];
	wire bare_strobe = (bit_cnt_ff == 6'd0);
	wire good_count = (bit_cnt_ff[1:0] == 2'b00) && !bare_strobe;
	wire [3:0] exec_cmd = bare_strobe ? rpt_cmd_ff : f_cmd;
	wire exec_ok = bare_strobe ? rpt_ok_ff : good_count;
	wire frame_go = cs_rise && exec_ok && (state_ff == ST_IDLE);
	wire shift_en = !cs_s && sclk_rise && (state_ff != ST_STORE);
	wire dec_halve = (exec_cmd == `CMD_HALVE_A) ||
		(exec_cmd == `CMD_HALVE_B);
	wire dec_double = (exec_cmd == `CMD_DOUBLE_A) ||
		(exec_cmd == `CMD_DOUBLE_B);
	wire dec_down = (exec_cmd == `CMD_DEC_A) ||
		(exec_cmd == `CMD_DEC_B);
	wire dec_up = (exec_cmd == `CMD_INC_A) ||
		(exec_cmd == `CMD_INC_B);
	wire is_adjust = dec_halve | dec_double | dec_down | dec_up;

	// serial shifter, frozen while a store runs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_ff <= 24'h000000;
			bit_cnt_ff <= 6'd0;
			last_word_ff <= 24'h000000;
		end else if (ce) begin
			if (shift_en) begin
				shift_ff <= {shift_ff[22:0], sdi_s};
				bit_cnt_ff <= (bit_cnt_ff == 6'd63) ? bit_cnt_ff :
					bit_cnt_ff + 6'd1;
			end
			// cs rise wins so the count always clears at frame end
			if (cs_rise) begin
				bit_cnt_ff <= 6'd0;
				if (good_count && state_ff != ST_STORE) begin
					last_word_ff <= shift_ff;
				end
			end
		end
	end

	// first echo bit leaves on the first rising edge, the rest on falling
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sdo_o_ff <= 1'b1;
		end else if (ce) begin
			if (cs_s) begin
				sdo_o_ff <= 1'b1;
			end else if (sclk_fall) begin
				sdo_o_ff <= out_ff[23];
			end else if (shift_en && bit_cnt_ff == 6'd0) begin
				sdo_o_ff <= out_ff[23];
			end
		end
	end

	// saturating adjustment result
	reg [9:0] nxt_adj;
	always @* begin
		nxt_adj = wiper_ff;
		case (exec_cmd)
		`CMD_HALVE_A, `CMD_HALVE_B: nxt_adj = {1'b0, wiper_ff[9:1]};
		`CMD_DOUBLE_A, `CMD_DOUBLE_B: begin
			nxt_adj = wiper_ff[9] ? `WIPER_FULL : {wiper_ff[8:0], 1'b0};
		end
		`CMD_DEC_A, `CMD_DEC_B: begin
			nxt_adj = (wiper_ff == 10'h000) ? 10'h000 : wiper_ff - 10'h001;
		end
		`CMD_INC_A, `CMD_INC_B: begin
			nxt_adj = (wiper_ff == `WIPER_FULL) ? `WIPER_FULL :
				wiper_ff + 10'h001;
		end
		default: nxt_adj = wiper_ff;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_ff <= 24'h000000;
			pr_pend_ff <= 1'b0;
			rpt_cmd_ff <= `CMD_NOP;
			rpt_ok_ff <= 1'b0;
			wiper_ff <= `WIPER_MID;
			state_ff <= ST_POR;
			timer_ff <= 32'h00000000;
			nv_addr_ff <= `WIPER_ADDR;
			nv_wdata_ff <= 16'h0000;
			nv_we_ff <= 1'b0;
			nv_rd_is_read_ff <= 1'b0;
			rdy_o_ff <= 1'b1;
			busy_ff <= 1'b1;
		end else if (ce) begin
			nv_we_ff <= 1'b0;
			if (shift_en) begin
				out_ff <= {out_ff[22:0], 1'b0};
			end
			if (cs_rise && good_count && state_ff != ST_STORE) begin
				out_ff <= shift_ff;
			end
			if (pr_rise && state_ff != ST_IDLE) begin
				pr_pend_ff <= 1'b1;
			end
			case (state_ff)
			ST_POR: begin
				nv_addr_ff <= `WIPER_ADDR;
				timer_ff <= 32'd`RESTORE_CYCLES;
				state_ff <= ST_POR_RD;
			end
			ST_POR_RD: begin
				if (timer_ff != 32'h0) begin
					timer_ff <= timer_ff - 32'h1;
				end else begin
					wiper_ff <= nv_rdata[9:0];
					busy_ff <= 1'b0;
					state_ff <= ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (pr_rise || pr_pend_ff) begin
					pr_pend_ff <= 1'b0;
					nv_addr_ff <= `WIPER_ADDR;
					nv_rd_is_read_ff <= 1'b0;
					timer_ff <= 32'd`RESTORE_CYCLES;
					busy_ff <= 1'b1;
					state_ff <= ST_RD_WAIT;
				end else if (frame_go) begin
					if (!bare_strobe) begin
						rpt_cmd_ff <= f_cmd;
						rpt_ok_ff <= is_adjust;
					end
					case (exec_cmd)
					`CMD_WRITE_WIPER: begin
						if (wp_s && f_addr == `WIPER_ADDR) begin
							wiper_ff <= shift_ff[9:0];
						end
					end
					`CMD_STORE_WIPER, `CMD_STORE_ANY: begin
						nv_addr_ff <= (exec_cmd == `CMD_STORE_WIPER) ?
							`WIPER_ADDR : f_addr;
						// store to wiper address saves the wiper itself
						nv_wdata_ff <= (exec_cmd == `CMD_STORE_WIPER ||
							f_addr == `WIPER_ADDR) ?
							{6'h00, wiper_ff} : shift_ff[15:0];
						nv_we_ff <= wp_s;
						timer_ff <= STORE_CYCLES;
						busy_ff <= 1'b1;
						state_ff <= ST_STORE;
					end
					`CMD_RESTORE, `CMD_RESET_NV: begin
						nv_addr_ff <= `WIPER_ADDR;
						nv_rd_is_read_ff <= 1'b0;
						timer_ff <= 32'd`RESTORE_CYCLES;
						busy_ff <= 1'b1;
						state_ff <= ST_RD_WAIT;
					end
					`CMD_READ_NV: begin
						nv_addr_ff <= f_addr;
						nv_rd_is_read_ff <= 1'b1;
						timer_ff <= 32'd`RESTORE_CYCLES;
						busy_ff <= 1'b1;
						state_ff <= ST_RD_WAIT;
					end
					`CMD_READ_WIPER: begin
						out_ff <= {shift_ff[23:10], wiper_ff};
						timer_ff <= 32'd`READY_PULSE_CYCLES;
						rdy_o_ff <= 1'b0;
						// busy covers the ready pulse of a wiper readback too
						busy_ff <= 1'b1;
						state_ff <= ST_READY;
					end
					default: begin
						if (wp_s && is_adjust) begin
							wiper_ff <= nxt_adj;
						end
					end
					endcase
				end
			end
			ST_STORE: begin
				if (timer_ff != 32'h0) begin
					timer_ff <= timer_ff - 32'h1;
				end else begin
					timer_ff <= 32'd`READY_PULSE_CYCLES;
					rdy_o_ff <= 1'b0;
					state_ff <= ST_READY;
				end
			end
			ST_RD_WAIT: begin
				if (timer_ff != 32'h0) begin
					timer_ff <= timer_ff - 32'h1;
				end else begin
					state_ff <= ST_RD_DONE;
				end
			end
			ST_RD_DONE: begin
				// restores bypass write protect
				if (nv_rd_is_read_ff) begin
					out_ff <= {last_word_ff[23:16], nv_rdata};
				end else begin
					wiper_ff <= nv_rdata[9:0];
				end
				timer_ff <= 32'd`READY_PULSE_CYCLES;
				rdy_o_ff <= 1'b0;
				state_ff <= ST_READY;
			end
			ST_READY: begin
				if (timer_ff != 32'h0) begin
					timer_ff <= timer_ff - 32'h1;
				end else begin
					rdy_o_ff <= 1'b1;
					busy_ff <= 1'b0;
					state_ff <= ST_IDLE;
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

//--- bench/wiper_ctrl_props.sv
// port timing checker for the wiper control block
`timescale 1ns/1ps
module wiper_ctrl_props (
	input wire clk,
	input wire rst_b,
	input wire cs_n,
	input wire wp_n,
	input wire preset_strobe_n,
	input wire sdo_oe_n,
	input wire rdy_o_ff,
	input wire [9:0] wiper_pos,
	input wire busy_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_sdo_off; cs_n[*4] |-> sdo_oe_n; endproperty
	a_sdo_off: assert property (p_sdo_off) else $error("sdo held");
	property p_rdy_len; $fell(rdy_o_ff) |-> (!rdy_o_ff)[*8]; endproperty
	a_rdy_len: assert property (p_rdy_len) else $error("short ready");
	property p_rdy_busy; $fell(rdy_o_ff) |-> busy_ff[*8]; endproperty
	a_rdy_busy: assert property (p_rdy_busy) else $error("idle ready");
	property p_rdy_idle; !busy_ff |-> rdy_o_ff; endproperty
	a_rdy_idle: assert property (p_rdy_idle) else $error("ready low");
	property p_mid;
		(!preset_strobe_n)[*4] |-> wiper_pos == 10'h200;
	endproperty
	a_mid: assert property (p_mid) else $error("not midscale");
	property p_por;
		$rose(rst_b) |-> busy_ff && wiper_pos == 10'h200;
	endproperty
	a_por: assert property (p_por) else $error("no restore");
	// restores run under busy, so an idle protected wiper must not move
	property p_wp;
		(preset_strobe_n && !wp_n && !busy_ff)[*8] |=> $stable(wiper_pos);
	endproperty
	a_wp: assert property (p_wp) else $error("protect broken");
	property p_cs;
		(!cs_n && preset_strobe_n && !busy_ff)[*8] |=> $stable(wiper_pos);
	endproperty
	a_cs: assert property (p_cs) else $error("early decode");
	c_store: cover property ($fell(rdy_o_ff));
	c_preset: cover property ((!preset_strobe_n)[*4]);
	c_protect: cover property (!wp_n && $changed(wiper_pos));
endmodule
bind wiper_ctrl wiper_ctrl_props wiper_ctrl_props_i (.clk, .rst_b, .cs_n,
	.wp_n, .preset_strobe_n, .sdo_oe_n, .rdy_o_ff, .wiper_pos, .busy_ff);

//--- bench/spi_host.sv
// serial host model: frames out on sdi, echo taken from sdo
`timescale 1ns/1ps
module spi_host (
	output reg sclk,
	output reg sdi,
	output reg cs_n,
	input wire sdo_oe_n,
	output reg [23:0] echo
);
	initial begin
		sclk = 0;
		sdi = 0;
		cs_n = 1;
		echo = 0;
	end
	// sclk stands low between frames; released sdo reads high (pull-up)
	task frame(input [23:0] w, input integer nb);
		integer i;
		begin
			cs_n = 0;
			for (i = nb - 1; i >= 0; i = i - 1) begin
				sdi = w[i];
				#62.5 sclk = 1;
				#62.5 echo = {echo[22:0], sdo_oe_n};
				sclk = 0;
			end
			#62.5 cs_n = 1;
			sdi = ~sdi;
			#250;
		end
	endtask
endmodule

//--- bench/test_digital_pot_wiper_control.sv
// self-checking bench for the wiper control block
`timescale 1ns/1ps
`include "pot_map.vh"
module test_digital_pot_wiper_control;
	reg clk, rst_b, wp_n, preset_strobe_n;
	wire sclk, sdi, cs_n, sdo_o_ff, sdo_oe_n, rdy_o_ff, rdy_oe_n, busy_ff;
	wire [9:0] wiper_pos;
	wire [23:0] echo;
	integer fails, tests_run, rdy_n, r0, n;
	reg [9:0] exp_q[$];
	reg [15:0] d;
	reg [9:0] v;
	reg [3:0] c;
	event chk;
	wiper_ctrl #(.STORE_CYCLES(2000)) wiper_ctrl_i (.clk, .rst_b,
		.ce(1'b1), .sclk, .sdi, .cs_n, .wp_n, .preset_strobe_n, .sdo_o_ff,
		.sdo_oe_n, .rdy_o_ff, .rdy_oe_n, .wiper_pos, .busy_ff);
	spi_host spi_host_i (.sclk, .sdi, .cs_n, .sdo_oe_n, .echo);
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(negedge rdy_oe_n) rdy_n = rdy_n + 1;
	always @(chk) #2 check(wiper_pos, exp_q.pop_front());
	task check(input [23:0] seen, input [23:0] want);
		begin
			tests_run = tests_run + 1;
			if (seen !== want) begin
				fails = fails + 1;
				$display("wrong value at %0t: %h expected %h", $time, seen,
					want);
			end
		end
	endtask
	task idle;
		integer k;
		begin
			repeat (10) @(posedge clk);
			for (k = 0; busy_ff !== 1'b0; k = k + 1) begin
				if (k == 3000) fails = fails + 1;
				@(posedge clk);
			end
			#1;
		end
	endtask
	task send(input [23:0] w, input integer nb, input [9:0] e);
		begin
			spi_host_i.frame(w, nb);
			idle;
			exp_q.push_back(e);
			-> chk;
		end
	endtask
	function [9:0] adj(input [3:0] op, input [9:0] w);
		case (op[3:1])
			3'h2: adj = w >> 1;
			3'h3: adj = (w == 10'h000) ? w : w - 10'h001;
			3'h6: adj = w[9] ? `WIPER_FULL : w << 1;
			default: adj = (w == `WIPER_FULL) ? w : w + 10'h001;
		endcase
	endfunction
	task final_report;
		begin
			$display("compared %0d, wrong %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#400000;
		fails = fails + 1;
		final_report;
	end
	initial begin
		fails = 0;
		tests_run = 0;
		rdy_n = 0;
		rst_b = 0;
		wp_n = 1;
		preset_strobe_n = 1;
		n = $urandom(26);
		repeat (20) @(posedge clk);
		#1 rst_b = 1;
		idle;
		check(wiper_pos, `WIPER_MID);
		// boundaries first so every adjust code meets its saturation
		for (n = 0; n < 16; n = n + 1) begin
			d = n[3] ? $urandom : (n[2] ? 16'h03FF : 16'h0000);
			c = {n[2], 1'b1, n[1:0]};
			send({8'hB0, d}, 24, d[9:0]);
			v = adj(c, d[9:0]);
			send({c, 20'h00000}, 24, v);
			check(echo, {8'hB0, d});
			send(24'h000000, 0, adj(c, v));
			check(sdo_oe_n, 1'b1);
			check(sdo_o_ff, 1'b1);
		end
		$display("adjust test done");
		r0 = rdy_n;
		send(24'hB00155, 24, 10'h155);
		spi_host_i.frame(24'h200000, 24);
		check(busy_ff, 1'b1);
		send(24'hB00000, 24, 10'h155);
		check(rdy_n, r0 + 1);
		send(24'hB00000, 24, 10'h000);
		check(echo, 24'h200000);
		send(24'h100000, 24, 10'h155);
		r0 = rdy_n;
		send(24'hB00000, 24, 10'h000);
		send(24'h800000, 24, 10'h155);
		send(24'h35BEEF, 24, 10'h155);
		send(24'h950000, 24, 10'h155);
		send(24'hA00000, 24, 10'h155);
		check(echo[15:0], 16'hBEEF);
		send(24'h900000, 24, 10'h155);
		check(echo[9:0], 10'h155);
		send(24'h000000, 24, 10'h155);
		check(echo[15:0], 16'h0155);
		check(rdy_n, r0 + 5);
		$display("store test done");
		send(24'hB00000, 24, 10'h000);
		wp_n = 0;
		send(24'hB00321, 24, 10'h000);
		send(24'hF00000, 24, 10'h000);
		send(24'h100000, 24, 10'h155);
		send(24'h000000, 24, 10'h155);
		wp_n = 1;
		$display("protect test done");
		send(24'hB00000, 24, 10'h000);
		r0 = rdy_n;
		preset_strobe_n = 0;
		repeat (10) @(posedge clk);
		#1 check(wiper_pos, `WIPER_MID);
		preset_strobe_n = 1;
		send(24'h000000, 24, 10'h155);
		check(rdy_n, r0 + 1);
		$display("preset test done");
		send(24'hB003FF, 22, 10'h155);
		$display("count test done");
		final_report;
	end
endmodule
